// File: verilog/dcd_pkg.sv
// shared constants, states and carriers of the disk command decoder
package dcd_pkg;
	// clock and stepping times
	localparam int CLK_NS = 10;
	localparam int STEP_3MS_NS = 3000000;
	localparam int STEP_2MS_NS = 2000000;
	localparam int STEP_200US_NS = 200000;
	localparam int STEP_70US_NS = 70000;
	localparam int STEP_30US_NS = 30000;
	localparam int STEP_15US_NS = 15000;
	localparam int STEP_CW = 20;
	localparam logic [3:0] SETTLE_CYC = 4'h4;
	// command block layout
	localparam logic [2:0] CMD_LAST = 3'h5;
	localparam logic [2:0] SENSE_LAST = 3'h3;
	localparam int CTL_BYTE = 5;
	localparam int CTL_FILL_BIT = 5;
	localparam int CTL_REREAD_BIT = 6;
	localparam int CTL_RETRY_BIT = 7;
	localparam logic [7:0] FILL_CONST = 8'h6c;
	localparam logic [3:0] RETRY_MAX = 4'h8;
	// command classes and opcodes
	localparam logic [2:0] CLS_0 = 3'h0;
	localparam logic [2:0] CLS_7 = 3'h7;
	localparam logic [4:0] OP_TEST = 5'h00;
	localparam logic [4:0] OP_RESTORE = 5'h01;
	localparam logic [4:0] OP_STATUS = 5'h03;
	localparam logic [4:0] OP_READ = 5'h08;
	// error codes
	localparam logic [5:0] ERR_NONE = 6'h00;
	localparam logic [5:0] ERR_NO_SEEK = 6'h02;
	localparam logic [5:0] ERR_WFAULT = 6'h03;
	localparam logic [5:0] ERR_NOT_READY = 6'h04;
	localparam logic [5:0] ERR_TRK0 = 6'h06;
	localparam logic [5:0] ERR_UNCORR = 6'h11;
	localparam logic [5:0] ERR_NO_AM = 6'h12;
	localparam logic [5:0] ERR_SEEK = 6'h15;
	localparam logic [5:0] ERR_CORR = 6'h18;
	localparam logic [5:0] ERR_BAD_TRK = 6'h19;
	localparam logic [5:0] ERR_FORMAT = 6'h1a;
	localparam logic [5:0] ERR_INVALID = 6'h20;
	localparam logic [5:0] ERR_BAD_ADDR = 6'h21;
	// retry actions toward the executor
	typedef enum logic [1:0] {
		ACT_RETRY = 2'b00,
		ACT_RESEEK = 2'b01,
		ACT_GIVE_UP = 2'b10
	} dcd_act_t;
	// control states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_CMD = 4'b0001,
		ST_DECODE = 4'b0010,
		ST_TEST = 4'b0011,
		ST_RSTR = 4'b0100,
		ST_EXEC = 4'b0101,
		ST_SENSE = 4'b0110,
		ST_STAT = 4'b0111,
		ST_CMPL = 4'b1000
	} dcd_state_t;
	// command handed to the read/write/format executor
	typedef struct packed {
		logic [2:0] cls;
		logic [4:0] op;
		logic [2:0] lun;
		logic [20:0] lba;
		logic [7:0] interleave;
		logic [3:0] step;
		logic half_step;
		logic fill_from_buf;
		logic [7:0] fill_byte;
		logic skip_reread;
		logic retry_en;
	} dcd_exec_t;
	// completion report from the executor
	typedef struct packed {
		logic [5:0] err;
		logic [20:0] lba;
	} dcd_result_t;
endpackage

// File: verilog/dcd_top.sv
// command decoder, retry policy and status reporting of the disk controller
`timescale 1ns/1ps
// Contract
// - seek commands take step algorithm from control byte bits 0-3
// - format fills with hex 6C if bit 5 clear, else sector buffer
// - winchester read with bit 6 set skips reread, goes to correction
// - ID-reading commands: bit 7 set disables retries, clear enables them
// - host zeroes unused control fields; unused control byte ignored entirely
// - failed read: up to 8 retries, reseek, then up to 8 more
// - step codes 0,2,9 3ms; 4 200us; 5 70us; 6 30us; 7 15us; 8 2ms
// - codes 1 and 3 are half-step modes; B-F behave as 3ms
// - status byte: bit 1 error, bits 5-7 unit, others zero
// - one status byte is sent at the end of every command
// - status byte unit number copied from the received command block
// - an all-zero completion byte follows every status byte
// - byte 0 holds class and opcode, byte 1 holds unit number
// - class 0 op 0 selects drive, tests ready and busy
// - class 0 op 1 steps heads to cylinder zero
// - class 0 op 3 returns error byte plus three address bytes
// - RAM, ROM and correction failures are logged against drive 0; code logs diag_err only in ST_IDLE when no command byte arrives
// - error byte: bit 7 address valid, bit 6 zero, bits 0-5 code
// - address bytes carry unit and address bits 16-20, 8-15, 0-7
// - address valid only if last non-status command used an address
// - on error report failing track for format, failing sector otherwise
// - on success report next track for format, last sector otherwise
// - error codes 11,12,15,18,19,1A,20,21 carry their listed meanings
// - invalid class, opcode, interleave or step code reports code 20
module dcd_top #(
	parameter int SECT_PER_TRK = 17,
	parameter int MAX_STEPS = 1024,
	parameter int CYC_3MS = (dcd_pkg::STEP_3MS_NS + dcd_pkg::CLK_NS - 1) / dcd_pkg::CLK_NS,
	parameter int CYC_2MS = (dcd_pkg::STEP_2MS_NS + dcd_pkg::CLK_NS - 1) / dcd_pkg::CLK_NS,
	parameter int CYC_200US = (dcd_pkg::STEP_200US_NS + dcd_pkg::CLK_NS - 1) / dcd_pkg::CLK_NS,
	parameter int CYC_70US = (dcd_pkg::STEP_70US_NS + dcd_pkg::CLK_NS - 1) / dcd_pkg::CLK_NS,
	parameter int CYC_30US = (dcd_pkg::STEP_30US_NS + dcd_pkg::CLK_NS - 1) / dcd_pkg::CLK_NS,
	parameter int CYC_15US = (dcd_pkg::STEP_15US_NS + dcd_pkg::CLK_NS - 1) / dcd_pkg::CLK_NS
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// command bytes from the host side
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_byte,
	output logic cmd_ready,
	// bytes returned to the host side
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	output logic bus_released,
	// drive pins
	input wire logic drv_ready_pin,
	input wire logic drv_busy_pin,
	input wire logic drv_fault_pin,
	input wire logic drv_track0_pin,
	output logic [2:0] drv_sel,
	output logic drv_step,
	output logic drv_dir_out,
	// executor of read, write, format and seek commands
	output logic exec_start,
	output dcd_pkg::dcd_exec_t exec_cmd,
	output logic [dcd_pkg::STEP_CW-1:0] exec_step_cyc,
	input wire logic exec_fail,
	output logic exec_act_valid,
	output dcd_pkg::dcd_act_t exec_act,
	input wire logic exec_done,
	input wire dcd_pkg::dcd_result_t exec_res,
	// controller diagnostic failures
	input wire logic diag_valid,
	input wire logic [5:0] diag_err,
	// block status
	output logic busy
);
	import dcd_pkg::*;
	dcd_state_t state;
	logic [7:0] cmd_blk [6];
	logic [2:0] idx;
	logic [2:0] cur_lun;
	logic [5:0] cur_err;
	logic [STEP_CW-1:0] cnt;
	logic [15:0] steps;
	logic [3:0] rcnt;
	logic reseeked;
	logic retry_en;
	logic [5:0] sense_err [8];
	logic sense_valid [8];
	logic [20:0] sense_lba [8];
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;
	// two-stage synchroniser for the drive pins
	always_ff @(posedge clk) begin
		pin_meta <= {drv_track0_pin, drv_fault_pin, drv_busy_pin, drv_ready_pin};
		pin_sync <= pin_meta;
	end
	wire s_ready = pin_sync[0];
	wire s_busy = pin_sync[1];
	wire s_fault = pin_sync[2];
	wire s_track0 = pin_sync[3];
	// step period per algorithm code
	function automatic logic [STEP_CW-1:0] step_cycles(input logic [3:0] code);
		case (code)
			4'h4: step_cycles = STEP_CW'(CYC_200US);
			4'h5: step_cycles = STEP_CW'(CYC_70US);
			4'h6: step_cycles = STEP_CW'(CYC_30US);
			4'h7: step_cycles = STEP_CW'(CYC_15US);
			4'h8: step_cycles = STEP_CW'(CYC_2MS);
			default: step_cycles = STEP_CW'(CYC_3MS);
		endcase
	endfunction
	// command classifiers
	function automatic logic cmd_known(input logic [2:0] c, input logic [4:0] o);
		if (c == CLS_0) begin
			cmd_known = (o <= 5'h10) && (o != 5'h02) && (o != 5'h09);
		end else if (c == CLS_7) begin
			cmd_known = (o == 5'h00) || (o == 5'h03) || (o == 5'h04) || (o == 5'h05) || (o == 5'h06);
		end else begin
			cmd_known = 1'b0;
		end
	endfunction
	function automatic logic is_format(input logic [2:0] c, input logic [4:0] o);
		is_format = (c == CLS_0) && ((o >= 5'h04 && o <= 5'h07) || o == 5'h0e);
	endfunction
	function automatic logic uses_step(input logic [2:0] c, input logic [4:0] o);
		uses_step = is_format(c, o) || (c == CLS_0 && (o == OP_READ || o == 5'h0a || o == 5'h0b))
			|| (c == CLS_7 && (o == 5'h03 || o == 5'h05 || o == 5'h06));
	endfunction
	function automatic logic uses_lba(input logic [2:0] c, input logic [4:0] o);
		uses_lba = is_format(c, o) || (c == CLS_0 && (o == OP_READ || o == 5'h0a || o == 5'h0b))
			|| (c == CLS_7 && (o == 5'h05 || o == 5'h06));
	endfunction
	// field decode of the received command block
	// class, opcode and unit fields
	wire [2:0] d_cls = cmd_blk[0][7:5];
	wire [4:0] d_op = cmd_blk[0][4:0];
	wire [2:0] d_lun = cmd_blk[1][7:5];
	wire [20:0] d_lba = {cmd_blk[1][4:0], cmd_blk[2], cmd_blk[3]};
	wire [7:0] d_ilv = cmd_blk[4];
	wire d_fmt = is_format(d_cls, d_op);
	wire d_step_used = uses_step(d_cls, d_op);
	wire d_lba_used = uses_lba(d_cls, d_op);
	// unused control byte treated as zero
	wire [7:0] d_ctl = d_step_used ? cmd_blk[CTL_BYTE] : 8'h00;
	wire [3:0] d_step = d_ctl[3:0];
	wire d_bad_step = d_step_used && (d_step == 4'ha);
	wire d_bad_ilv = d_fmt && (d_op != 5'h07) && (d_op != 5'h0e) && (d_ilv == 8'h00);
	wire d_invalid = !cmd_known(d_cls, d_op) || d_bad_step || d_bad_ilv;
	wire d_is_read = (d_cls == CLS_0) && (d_op == OP_READ);
	// executor command build
	// codes 1 and 3 select half-step
	wire d_half = (d_step == 4'h1) || (d_step == 4'h3);
	wire d_fill_buf = d_fmt && d_ctl[CTL_FILL_BIT];
	wire d_skip_reread = d_is_read && d_ctl[CTL_REREAD_BIT];
	wire d_retry_en = !d_ctl[CTL_RETRY_BIT];
	wire dcd_exec_t d_exec = '{cls: d_cls, op: d_op, lun: d_lun, lba: d_lba, interleave: d_ilv,
		step: d_step, half_step: d_half, fill_from_buf: d_fill_buf, fill_byte: FILL_CONST,
		skip_reread: d_skip_reread, retry_en: d_retry_en};
	// drive-ready test result
	// ready and busy evaluation
	wire [5:0] test_err = s_fault ? ERR_WFAULT : (!s_ready ? ERR_NOT_READY : (s_busy ? ERR_NO_SEEK : ERR_NONE));
	// stored address after an executed command
	// format success reports next track
	wire [20:0] res_lba = (exec_res.err == ERR_NONE && exec_cmd.cls == CLS_0 && is_format(exec_cmd.cls, exec_cmd.op))
		? exec_res.lba + 21'(SECT_PER_TRK) : exec_res.lba;
	// bytes sent back to the host
	// error byte layout
	wire [7:0] sense_b0 = {sense_valid[cur_lun], 1'b0, sense_err[cur_lun]};
	wire [20:0] s_lba = sense_lba[cur_lun];
	wire [7:0] sense_byte = (idx == 3'h0) ? sense_b0 : (idx == 3'h1) ? {cur_lun, s_lba[20:16]}
		: (idx == 3'h2) ? s_lba[15:8] : s_lba[7:0];
	wire [7:0] status_byte = {cur_lun, 3'b000, (cur_err != ERR_NONE), 1'b0};
	wire tx_take = tx_valid && tx_ready;
	// retry decision on a failed read attempt
	// eight retries, reseek, eight more
	wire dcd_act_t next_act = !retry_en ? ACT_GIVE_UP : (rcnt < RETRY_MAX) ? ACT_RETRY
		: (!reseeked ? ACT_RESEEK : ACT_GIVE_UP);
	// command sequencer and per-drive sense store
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			idx <= 3'h0;
			cur_lun <= 3'h0;
			cur_err <= ERR_NONE;
			cnt <= '0;
			steps <= 16'h0000;
			rcnt <= 4'h0;
			reseeked <= 1'b0;
			retry_en <= 1'b0;
			cmd_ready <= 1'b1;
			tx_valid <= 1'b0;
			tx_data <= 8'h00;
			bus_released <= 1'b0;
			drv_sel <= 3'h0;
			drv_step <= 1'b0;
			drv_dir_out <= 1'b0;
			exec_start <= 1'b0;
			exec_cmd <= '0;
			exec_step_cyc <= '0;
			exec_act_valid <= 1'b0;
			exec_act <= ACT_RETRY;
			busy <= 1'b0;
			for (int i = 0; i < 6; i++) begin
				cmd_blk[i] <= 8'h00;
			end
			for (int i = 0; i < 8; i++) begin
				sense_err[i] <= ERR_NONE;
				sense_valid[i] <= 1'b0;
				sense_lba[i] <= 21'h0;
			end
		end else begin
			exec_start <= 1'b0;
			exec_act_valid <= 1'b0;
			drv_step <= 1'b0;
			bus_released <= 1'b0;
			case (state)
				ST_IDLE: begin
					busy <= 1'b0;
					if (cmd_valid) begin
						cmd_blk[0] <= cmd_byte;
						idx <= 3'h1;
						busy <= 1'b1;
						state <= ST_CMD;
					end else if (diag_valid) begin
						// diagnostic failures logged on drive 0
						sense_err[0] <= diag_err;
						sense_valid[0] <= 1'b0;
					end
				end
				ST_CMD: begin
					if (cmd_valid) begin
						cmd_blk[idx] <= cmd_byte;
						idx <= idx + 3'h1;
						if (idx == CMD_LAST) begin
							cmd_ready <= 1'b0;
							state <= ST_DECODE;
						end
					end
				end
				ST_DECODE: begin
					cur_lun <= d_lun;
					drv_sel <= d_lun;
					idx <= 3'h0;
					cnt <= STEP_CW'(SETTLE_CYC);
					steps <= 16'h0000;
					if (d_invalid) begin
						cur_err <= ERR_INVALID;
						sense_err[d_lun] <= ERR_INVALID;
						sense_valid[d_lun] <= 1'b0;
						state <= ST_STAT;
					end else if (d_cls == CLS_0 && d_op == OP_TEST) begin
						state <= ST_TEST;
					end else if (d_cls == CLS_0 && d_op == OP_RESTORE) begin
						drv_dir_out <= 1'b1;
						state <= ST_RSTR;
					end else if (d_cls == CLS_0 && d_op == OP_STATUS) begin
						cur_err <= ERR_NONE;
						state <= ST_SENSE;
					end else begin
						exec_cmd <= d_exec;
						exec_step_cyc <= step_cycles(d_step);
						exec_start <= 1'b1;
						retry_en <= d_retry_en;
						rcnt <= 4'h0;
						reseeked <= 1'b0;
						state <= ST_EXEC;
					end
				end
				ST_TEST: begin
					if (cnt != '0) begin
						cnt <= cnt - STEP_CW'(1);
					end else begin
						cur_err <= test_err;
						sense_err[cur_lun] <= test_err;
						sense_valid[cur_lun] <= 1'b0;
						state <= ST_STAT;
					end
				end
				ST_RSTR: begin
					if (cnt != '0) begin
						cnt <= cnt - STEP_CW'(1);
					end else if (s_track0 || s_fault || !s_ready || steps == 16'(MAX_STEPS)) begin
						cur_err <= s_fault ? ERR_WFAULT : (!s_ready ? ERR_NOT_READY : (s_track0 ? ERR_NONE : ERR_TRK0));
						sense_err[cur_lun] <= s_fault ? ERR_WFAULT : (!s_ready ? ERR_NOT_READY
							: (s_track0 ? ERR_NONE : ERR_TRK0));
						sense_valid[cur_lun] <= 1'b0;
						drv_dir_out <= 1'b0;
						state <= ST_STAT;
					end else begin
						drv_step <= 1'b1;
						steps <= steps + 16'h0001;
						cnt <= STEP_CW'(CYC_3MS - 1);
					end
				end
				ST_EXEC: begin
					if (exec_done) begin
						cur_err <= exec_res.err;
						sense_err[cur_lun] <= exec_res.err;
						sense_valid[cur_lun] <= uses_lba(exec_cmd.cls, exec_cmd.op);
						sense_lba[cur_lun] <= res_lba;
						state <= ST_STAT;
					end else if (exec_fail) begin
						exec_act_valid <= 1'b1;
						exec_act <= next_act;
						if (next_act == ACT_RETRY) begin
							rcnt <= rcnt + 4'h1;
						end else if (next_act == ACT_RESEEK) begin
							rcnt <= 4'h0;
							reseeked <= 1'b1;
						end
					end
				end
				ST_SENSE: begin
					if (!tx_valid) begin
						tx_valid <= 1'b1;
						tx_data <= sense_byte;
					end else if (tx_take) begin
						tx_valid <= 1'b0;
						idx <= idx + 3'h1;
						if (idx == SENSE_LAST) begin
							state <= ST_STAT;
						end
					end
				end
				ST_STAT: begin
					if (!tx_valid) begin
						tx_valid <= 1'b1;
						tx_data <= status_byte;
					end else if (tx_take) begin
						tx_valid <= 1'b0;
						state <= ST_CMPL;
					end
				end
				ST_CMPL: begin
					if (!tx_valid) begin
						tx_valid <= 1'b1;
						tx_data <= 8'h00;
					end else if (tx_take) begin
						tx_valid <= 1'b0;
						bus_released <= 1'b1;
						cmd_ready <= 1'b1;
						busy <= 1'b0;
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end
endmodule

// File: testbench/dcd_chk_sva.sv
// port checker of the disk command decoder
`timescale 1ns/1ps
module dcd_chk #(
	parameter int CYC_2MS = 200000
) (
	// clock, reset
	input wire logic clk,
	input wire logic sys_rst,
	// host side
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic bus_released,
	input wire logic busy,
	// drive and executor
	input wire logic [2:0] drv_sel,
	input wire logic drv_step,
	input wire logic drv_dir_out,
	input wire logic exec_start,
	input wire dcd_pkg::dcd_exec_t exec_cmd,
	input wire logic [dcd_pkg::STEP_CW-1:0] exec_step_cyc,
	input wire logic exec_fail,
	input wire logic exec_act_valid,
	input wire dcd_pkg::dcd_act_t exec_act
);
	import dcd_pkg::*;
	logic [2:0] n_byte;
	logic [3:0] n_retry;
	logic [7:0] last_tx;
	logic [7:0] prev_tx;
	// byte and retry counts, last two host bytes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			n_byte <= 3'h0;
			n_retry <= 4'h0;
		end else begin
			if (cmd_valid && cmd_ready)
				n_byte <= busy ? n_byte + 3'h1 : 3'h1;
			if (exec_start)
				n_retry <= 4'h0;
			else if (exec_act_valid)
				n_retry <= exec_act == ACT_RETRY ? n_retry + 4'h1 : 4'h0;
		end
		if (tx_valid && tx_ready) begin
			prev_tx <= last_tx;
			last_tx <= tx_data;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_last_cmd;
		cmd_valid && cmd_ready && n_byte == 3'h5;
	endsequence
	sequence s_stall;
		tx_valid && !tx_ready;
	endsequence
	a_last_cmd_byte: assert property (s_last_cmd |=> !cmd_ready)
		else $error("intake open after sixth byte");
	a_busy_cover: assert property (!cmd_ready |-> busy)
		else $error("intake closed while idle");
	a_tx_hold: assert property (s_stall |=> tx_valid && $stable(tx_data))
		else $error("return byte changed before taken");
	a_cmpl_zero: assert property (bus_released |-> last_tx == 8'h00 && $past(tx_valid && tx_ready))
		else $error("release without zero completion byte");
	a_status_form: assert property (bus_released |-> (prev_tx & 8'h1d) == 8'h00 && prev_tx[7:5] == drv_sel)
		else $error("status byte malformed");
	a_act_answer: assert property (exec_fail |=> exec_act_valid)
		else $error("read failure not answered");
	a_retry_count: assert property (exec_act_valid && exec_cmd.retry_en |-> (exec_act == ACT_RETRY) == (n_retry != 4'h8))
		else $error("retry count wrong");
	a_retry_off: assert property (exec_act_valid && !exec_cmd.retry_en |-> exec_act == ACT_GIVE_UP)
		else $error("retry while disabled");
	a_fill_const: assert property (exec_start |-> exec_cmd.fill_byte == 8'h6c)
		else $error("fill constant wrong");
	a_step_2ms: assert property (exec_start && exec_cmd.step == 4'h8 |-> exec_step_cyc == CYC_2MS)
		else $error("step period wrong");
	a_half_step: assert property (exec_start |-> exec_cmd.half_step == (exec_cmd.step inside {4'h1, 4'h3}))
		else $error("half step flag wrong");
	a_dir_restore: assert property (drv_step |-> drv_dir_out)
		else $error("step away from cylinder zero");
endmodule
bind dcd_top dcd_chk #(.CYC_2MS(CYC_2MS)) u_chk (.clk, .sys_rst, .cmd_valid, .cmd_ready, .tx_valid, .tx_data,
	.tx_ready, .bus_released, .busy, .drv_sel, .drv_step, .drv_dir_out, .exec_start, .exec_cmd, .exec_step_cyc,
	.exec_fail, .exec_act_valid, .exec_act);

// File: testbench/dcd_host_model.sv
// host adapter model: sends command blocks, takes returned bytes
`timescale 1ns/1ps
module dcd_host_model (
	// clock
	input wire logic clk,
	// command bytes
	input wire logic cmd_ready,
	output logic cmd_valid,
	output logic [7:0] cmd_byte,
	// returned bytes
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	input wire logic slow
);
	logic [7:0] rx[$];
	logic [1:0] ph = 2'h0;
	initial begin
		cmd_valid = 1'b0;
		cmd_byte = 8'h00;
		tx_ready = 1'b0;
	end
	// takes each byte; stalls two cycles of three when slow
	always @(posedge clk) begin
		if (tx_valid && tx_ready)
			rx.push_back(tx_data);
		ph <= ph == 2'h2 ? 2'h0 : ph + 2'h1;
		tx_ready <= !slow || ph == 2'h2;
	end
	// six bytes in order, held until taken
	task automatic send(input logic [47:0] blk);
		for (int i = 5; i >= 0; i--) begin
			cmd_valid <= 1'b1;
			cmd_byte <= blk[8*i +: 8];
			@(negedge clk);
			while (cmd_ready !== 1'b1)
				@(negedge clk);
			@(posedge clk);
		end
		cmd_valid <= 1'b0;
		cmd_byte <= ~blk[7:0];
	endtask
endmodule

// File: testbench/dcd_top_bench.sv
// self-checking bench of the disk command decoder
`timescale 1ns/1ps
module dcd_top_bench;
	import dcd_pkg::*;
	localparam int C3 = 30, C2 = 20, C200 = 8, C70 = 7, C30 = 6, C15 = 5, SPT = 5;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic cmd_valid, cmd_ready, tx_valid, tx_ready, bus_released, drv_step, drv_dir_out, exec_start, exec_act_valid, busy;
	logic exec_fail = 1'b0, exec_done = 1'b0, diag_valid = 1'b0, slow = 1'b0;
	logic drv_ready_pin = 1'b1, drv_busy_pin = 1'b0, drv_fault_pin = 1'b0, drv_track0_pin = 1'b1;
	logic [7:0] cmd_byte, tx_data;
	logic [2:0] drv_sel;
	logic [5:0] diag_err = 6'h00;
	logic [STEP_CW-1:0] exec_step_cyc;
	logic [1:0] ev;
	dcd_exec_t exec_cmd;
	dcd_act_t exec_act;
	dcd_result_t exec_res = '0;
	int fail_count = 0, n_checks = 0, steps = 0;
	dcd_top #(.SECT_PER_TRK(SPT), .MAX_STEPS(4), .CYC_3MS(C3), .CYC_2MS(C2), .CYC_200US(C200), .CYC_70US(C70),
		.CYC_30US(C30), .CYC_15US(C15)) uut (.clk, .sys_rst, .cmd_valid, .cmd_byte, .cmd_ready, .tx_valid, .tx_data,
		.tx_ready, .bus_released, .drv_ready_pin, .drv_busy_pin, .drv_fault_pin, .drv_track0_pin, .drv_sel, .drv_step,
		.drv_dir_out, .exec_start, .exec_cmd, .exec_step_cyc, .exec_fail, .exec_act_valid, .exec_act, .exec_done,
		.exec_res, .diag_valid, .diag_err, .busy);
	dcd_host_model host (.clk, .cmd_ready, .cmd_valid, .cmd_byte, .tx_valid, .tx_data, .tx_ready, .slow);
	assign ev = {bus_released, exec_start};
	always #5 clk = ~clk;
	// counts step pulses toward the drive
	always @(posedge clk)
		if (drv_step === 1'b1)
			steps <= steps + 1;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// bounded wait for a pulse
	task automatic wait_ev(input int i);
		int k;
		for (k = 0; k < 3000 && ev[i] !== 1'b1; k++)
			@(posedge clk);
		if (k == 3000)
			chk(32'h0, 32'h1);
	endtask
	task automatic issue(input logic [47:0] b);
		host.rx.delete();
		host.send(b);
	endtask
	task automatic end_cmd(input logic [7:0] st, input int n);
		wait_ev(1);
		chk(host.rx.size(), n);
		chk({host.rx[n-2], host.rx[n-1]}, {st, 8'h00});
	endtask
	task automatic done(input logic [5:0] e, input logic [20:0] a);
		exec_res <= {e, a};
		exec_done <= 1'b1;
		@(posedge clk);
		exec_done <= 1'b0;
	endtask
	// sense data of one unit; address part masked when not meaningful
	task automatic sense(input logic [2:0] u, input logic [31:0] exp, input logic full);
		logic [31:0] got;
		issue({8'h03, u, 37'h0});
		end_cmd({u, 5'h00}, 6);
		got = {host.rx[0], host.rx[1], host.rx[2], host.rx[3]};
		chk(full ? got : got & 32'hffe00000, exp);
	endtask
	// test ready with don't-care bytes set
	task automatic pin_case(input logic f, input logic r, input logic b, input logic [5:0] e);
		drv_fault_pin <= f;
		drv_ready_pin <= r;
		drv_busy_pin <= b;
		issue({8'h00, 3'h2, 5'h1f, 32'hffffffff});
		end_cmd({3'h2, 3'h0, e != 6'h00, 1'b0}, 2);
		chk(drv_sel, 3'h2);
		sense(3'h2, {2'b00, e, 3'h2, 21'h0}, 1'b0);
	endtask
	// restore: missing track zero, then found
	task automatic t_restore();
		drv_track0_pin <= 1'b0;
		steps = 0;
		issue({8'h01, 3'h3, 29'h0, 8'hff});
		end_cmd(8'h62, 2);
		chk(steps, 4);
		sense(3'h3, {8'h06, 3'h3, 21'h0}, 1'b0);
		drv_track0_pin <= 1'b1;
		issue({8'h01, 3'h3, 37'h0});
		end_cmd(8'h60, 2);
	endtask
	// read with n failed attempts
	task automatic t_read(input logic [7:0] ctl, input int n, input int cyc);
		logic [5:0] e;
		e = n > 0 ? ERR_UNCORR : ERR_NONE;
		issue({8'h08, 3'h1, 21'h12345, 8'h01, ctl});
		wait_ev(0);
		chk({exec_cmd.lba, exec_cmd.step, exec_cmd.retry_en, exec_cmd.skip_reread},
			{21'h12345, ctl[3:0], !ctl[7], ctl[6]});
		chk(exec_step_cyc, cyc);
		for (int i = 0; i < n; i++) begin
			exec_fail <= 1'b1;
			@(posedge clk);
			exec_fail <= 1'b0;
			@(posedge clk);
			chk({exec_act_valid, exec_act},
				{1'b1, (ctl[7] || i == 17) ? ACT_GIVE_UP : (i == 8 ? ACT_RESEEK : ACT_RETRY)});
		end
		done(e, 21'h12346);
		end_cmd({3'h1, 3'h0, n > 0, 1'b0}, 2);
		sense(3'h1, {2'b10, e, 3'h1, 21'h12346}, 1'b1);
	endtask
	// seek through every step code
	task automatic t_steps();
		int cyc[16] = '{C3, C3, C3, C3, C200, C70, C30, C15, C2, C3, 0, C3, C3, C3, C3, C3};
		for (int s = 0; s < 16; s++) begin
			issue({8'h0b, 3'h4, 21'h00400, 8'h00, 4'h0, s[3:0]});
			if (s == 10) begin
				end_cmd(8'h82, 2);
				sense(3'h4, {8'h20, 3'h4, 21'h0}, 1'b0);
			end else begin
				wait_ev(0);
				chk({exec_step_cyc, exec_cmd.half_step}, {cyc[s][19:0], s == 1 || s == 3});
				done(ERR_NONE, 21'h00400);
				end_cmd(8'h80, 2);
			end
		end
	endtask
	// format fill choice and reported track
	task automatic t_format(input logic [7:0] ctl, input logic [5:0] e, input logic [20:0] a);
		issue({8'h04, 3'h7, 21'h00055, 8'h02, ctl});
		wait_ev(0);
		chk({exec_cmd.fill_from_buf, exec_cmd.fill_byte}, {ctl[5], 8'h6c});
		done(e, 21'h00055);
		end_cmd({3'h7, 3'h0, e != 6'h00, 1'b0}, 2);
		sense(3'h7, {2'b10, e, 3'h7, a}, 1'b1);
	endtask
	// class 7 commands through the executor; valid flag follows address use
	task automatic t_cls7(input logic [4:0] op, input logic [5:0] e, input logic v);
		issue({3'h7, op, 3'h5, 21'h00777, 8'h01, 8'h09});
		wait_ev(0);
		chk({exec_cmd.cls, exec_cmd.op, exec_cmd.lun, exec_step_cyc}, {3'h7, op, 3'h5, 20'(C3)});
		done(e, 21'h00777);
		end_cmd({3'h5, 3'h0, e != 6'h00, 1'b0}, 2);
		sense(3'h5, {v, 1'b0, e, 3'h5, v ? 21'h00777 : 21'h0}, v);
	endtask
	// reset in mid-run: idle outputs, sense store cleared
	task automatic t_reset();
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		chk({cmd_ready, tx_valid, tx_data, busy, bus_released, exec_start, exec_act_valid, drv_step, drv_dir_out,
			drv_sel}, {1'b1, 18'h0});
		sys_rst <= 1'b0;
		@(posedge clk);
		sense(3'h7, {8'h00, 3'h7, 21'h0}, 1'b1);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		pin_case(1'b0, 1'b1, 1'b0, 6'h00);
		pin_case(1'b1, 1'b0, 1'b1, 6'h03);
		pin_case(1'b0, 1'b0, 1'b1, 6'h04);
		pin_case(1'b0, 1'b1, 1'b1, 6'h02);
		drv_busy_pin <= 1'b0;
		t_restore();
		t_read(8'h04, 18, C200);
		t_read(8'hc8, 1, C2);
		t_read(8'h47, 0, C15);
		t_steps();
		slow <= 1'b1;
		t_format(8'h20, ERR_NONE, 21'h00055 + SPT);
		t_format(8'h00, ERR_SEEK, 21'h00055);
		issue({8'h04, 3'h7, 21'h00055, 16'h0000});
		end_cmd(8'he2, 2);
		issue({8'h60, 40'h0});
		end_cmd(8'h02, 2);
		diag_err <= 6'h31;
		diag_valid <= 1'b1;
		@(posedge clk);
		diag_valid <= 1'b0;
		sense(3'h0, {8'h31, 24'h0}, 1'b0);
		t_cls7(5'h05, ERR_CORR, 1'b1);
		t_cls7(5'h00, ERR_NONE, 1'b0);
		t_reset();
		complete_run();
	end
	// watchdog against a hang
	initial begin
		#200000;
		fail_count++;
		complete_run();
	end
endmodule
